// ---- dv/vcip_gfx_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Graphics controller model
// ----------------------------------------------------------------
module vcip_gfx_model (
	// Run enables and wanted activity, {blank, hsync, vsync} active high then pixel.
	input  wire logic        run_loop,
	input  wire logic        run_dot,
	input  wire logic [10:0] sys_v,
	input  wire logic [10:0] leg_v,
	// Pins toward the block.
	output logic             loop_clk_in,
	output logic             legacy_dot_clk_in,
	output logic [10:0]      sys_o,
	output logic [10:0]      leg_o
);
	// Link clocks of 200 ns that stand low while stopped, off phase with the system clock.
	initial begin
		loop_clk_in = 1'b0;
		legacy_dot_clk_in = 1'b0;
		sys_o = 11'h700;
		leg_o = 11'h700;
		#7;
		forever begin
			#100 loop_clk_in = run_loop & ~loop_clk_in;
			legacy_dot_clk_in = run_dot & ~legacy_dot_clk_in;
		end
	end

	// Data moves on the falling edge, far from the capture edge; controls go out active low.
	always @(negedge loop_clk_in) sys_o <= {~sys_v[10:8], sys_v[7:0]};
	always @(negedge legacy_dot_clk_in) leg_o <= {~leg_v[10:8], leg_v[7:0]};
endmodule : vcip_gfx_model

// ---- dv/vcip_top_bench.sv ----
`timescale 1ns/1ps
module vcip_top_bench
	import vcip_pkg::*;
;
	logic        sys_clk, rstn, reg_wr, reg_rd, flag, run_loop, run_dot;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, dac_pixel;
	logic [10:0] sys_v, leg_v, sp, lp;
	logic        loop_clk, dot_clk, shift_clk, dac_blank_n, hs_o, vs_o;
	int          n_fail, num_checks;

	// Free running 40 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	vcip_top u_vcip_top (
		.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_clk_in(loop_clk), .legacy_dot_clk_in(dot_clk),
		.sys_blank_n(sp[10]), .sys_hsync_in(sp[9]), .sys_vsync_in(sp[8]), .sys_pixel_port(sp[7:0]),
		.legacy_blank_n(lp[10]), .legacy_hsync_in(lp[9]), .legacy_vsync_in(lp[8]), .legacy_pixel_port(lp[7:0]),
		.split_transfer_flag(flag), .shift_clk_out(shift_clk), .dac_blank_n(dac_blank_n), .dac_pixel(dac_pixel),
		.hsync_output(hs_o), .vsync_output(vs_o)
	);

	vcip_gfx_model u_vcip_gfx_model (
		.run_loop(run_loop), .run_dot(run_dot), .sys_v(sys_v), .leg_v(leg_v),
		.loop_clk_in(loop_clk), .legacy_dot_clk_in(dot_clk), .sys_o(sp), .leg_o(lp)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Strobes drop after one edge; the spare edge keeps the next strobe out of this time step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(reg_rdata, exp);
		@(posedge sys_clk);
	endtask : rd

	// Bounded wait for a level of the loop clock pin; a stuck clock counts as a mismatch.
	task automatic wait_loop(input logic lvl);
		int n;
		n = 0;
		while (loop_clk !== lvl && n < 16) begin
			@(posedge sys_clk);
			n++;
		end
		if (loop_clk !== lvl) begin
			n_fail++;
			$display("unexpected at %0t: loop clock %h expected %h", $time, loop_clk, lvl);
		end
	endtask : wait_loop

	function automatic logic [10:0] pins(input logic [10:0] v);
		return {~v[10:8], v[7:0]};
	endfunction : pins

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		rd(REG_GEN_CTRL, 8'h00);
		rd(REG_MODE, MODE_RESET);
		rd(8'h00, 8'h00);
		wr(REG_GEN_CTRL, 8'h03);
		rd(REG_GEN_CTRL, 8'h03);
		rd(REG_STATUS, 8'h13);
		wr(REG_GEN_CTRL, 8'h00);
	endtask : t_regs

	task automatic t_path(input logic [7:0] mode, input logic [1:0] inv);
		logic [10:0] c;
		logic [7:0]  p;
		c = (mode[2:0] == 3'h2) ? pins(leg_v) : pins(sys_v);
		p = (mode[3] && (mode[2:0] == 3'h1 || mode[2:0] == 3'h2)) ? leg_v[7:0] : sys_v[7:0];
		wr(REG_GEN_CTRL, {6'h00, inv});
		wr(REG_MODE, mode);
		repeat (48) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(dac_pixel, p);
		chk({5'h00, dac_blank_n, vs_o, hs_o}, {5'h00, c[10], c[8] ^ inv[1], c[9] ^ inv[0]});
		@(posedge sys_clk);
	endtask : t_path

	task automatic t_modes();
		t_path(8'h00, 2'h0);
		t_path(8'h01, 2'h1);
		t_path(8'h02, 2'h2);
		t_path(8'h0A, 2'h3);
		t_path(8'h09, 2'h0);
		t_path(8'h08, 2'h0);
	endtask : t_modes

	// With the loop clock stopped the dot clock alone must not move the system path.
	// The new word reaches the pins on the last falling edge, so only a wrong clock could latch it.
	task automatic t_latch();
		wait_loop(1'b1);
		sys_v <= 11'h2A5;
		wait_loop(1'b0);
		run_loop <= 1'b0;
		repeat (48) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(dac_pixel, 8'h5A);
		@(posedge sys_clk);
		run_loop <= 1'b1;
		t_path(8'h00, 2'h0);
	endtask : t_latch

	// Blank, syncs and pixel of one link edge leave the pipeline together.
	task automatic t_delay();
		wait_loop(1'b1);
		sys_v <= 11'h43C;
		wait_loop(1'b0);
		#400;
		chk({dac_blank_n, hs_o, vs_o, dac_pixel[4:0]}, {3'b101, 5'h05});
		#600;
		chk({dac_blank_n, hs_o, vs_o, dac_pixel[4:0]}, {3'b011, 5'h1C});
		@(posedge sys_clk);
	endtask : t_delay

	task automatic t_shift();
		int hi;
		hi = 0;
		repeat (40) begin
			@(negedge sys_clk);
			hi += shift_clk;
		end
		chk(hi[7:0], 8'h00);
		@(posedge sys_clk);
		rd(REG_STATUS, 8'h03);
		flag <= 1'b1;
		repeat (10) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({7'h00, shift_clk}, 8'h01);
		@(posedge sys_clk);
		flag <= 1'b0;
		sys_v <= 11'h25A;
		repeat (80) @(posedge sys_clk);
		hi = 0;
		repeat (80) begin
			@(negedge sys_clk);
			hi += shift_clk;
		end
		chk({7'h00, hi > 30 && hi < 50}, 8'h01);
		@(posedge sys_clk);
	endtask : t_shift

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	// Reset for three cycles, then registers with the link idle, then the link scenarios.
	initial begin
		n_fail = 0;
		num_checks = 0;
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		flag = 1'b0;
		run_loop = 1'b0;
		run_dot = 1'b0;
		sys_v = 11'h25A;
		leg_v = 11'h5C3;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		t_regs();
		run_loop <= 1'b1;
		run_dot <= 1'b1;
		t_modes();
		t_latch();
		t_delay();
		t_shift();
		final_report();
	end
endmodule : vcip_top_bench

// ---- dv/vcip_top_props.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module vcip_top_props
	import vcip_pkg::*;
(
	// Clock and reset.
	input wire logic              sys_clk,
	input wire logic              rstn,
	// Register port.
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	// Link side.
	input wire logic              loop_clk_in,
	input wire logic              legacy_dot_clk_in,
	input wire logic              split_transfer_flag,
	// Outputs.
	input wire logic              shift_clk_out,
	input wire logic              dac_blank_n,
	input wire logic [PIX_W-1:0]  dac_pixel,
	input wire logic              hsync_output,
	input wire logic              vsync_output
);
	logic [1:0] inv_m;
	logic [1:0] inv_d;
	logic [3:0] mode_m;
	logic       leg2;
	logic       lpix;

	// Mirror of the inversion bits; the output register applies them one cycle after the write.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			inv_m <= 2'h0;
			inv_d <= 2'h0;
		end else begin
			if (reg_wr && reg_addr == REG_GEN_CTRL)
				inv_m <= reg_wdata[1:0];
			inv_d <= inv_m;
		end
	end

	// Mirror of the mode bits, starting in the legacy latching mode.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			mode_m <= MODE_RESET[3:0];
		else if (reg_wr && reg_addr == REG_MODE)
			mode_m <= reg_wdata[3:0];
	end

	// Decoded views of the mirrored mode.
	assign leg2 = mode_m[2:0] == 3'h2;
	assign lpix = mode_m[3] && (mode_m[2:0] == 3'h1 || leg2);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	AST_GCR_READ: assert property (reg_rd && reg_addr == REG_GEN_CTRL |=> reg_rdata[1:0] == $past(inv_m))
		else $error("inversion bits read back wrong");
	AST_MODE_READ: assert property (reg_rd && reg_addr == REG_MODE |=> reg_rdata[3:0] == $past(mode_m))
		else $error("mode bits read back wrong");
	AST_STATUS: assert property (reg_rd && reg_addr == REG_STATUS |=>
		reg_rdata[4:0] == {$past(leg2), $past(lpix), $past(dac_blank_n), $past(vsync_output), $past(hsync_output)})
		else $error("status read wrong");
	AST_HS_INV: assert property ((!loop_clk_in && !legacy_dot_clk_in)[*8] |->
		$stable(hsync_output ^ inv_d[0]))
		else $error("hsync output changed without a link edge");
	AST_VS_INV: assert property ((!loop_clk_in && !legacy_dot_clk_in)[*8] |->
		$stable(vsync_output ^ inv_d[1]))
		else $error("vsync output changed without a link edge");
	AST_HOLD_LOOP: assert property ((!leg2 && !loop_clk_in)[*8] |->
		$stable(dac_pixel) && $stable(dac_blank_n))
		else $error("pipeline moved without a loop clock edge");
	AST_HOLD_DOT: assert property ((leg2 && !legacy_dot_clk_in)[*8] |->
		$stable(dac_pixel) && $stable(dac_blank_n))
		else $error("pipeline moved without a dot clock edge");
	AST_SHIFT_OFF: assert property ((!dac_blank_n && !split_transfer_flag)[*6] |-> !shift_clk_out)
		else $error("shift clock ran during blank");
	AST_SHIFT_FLAG: assert property ((!dac_blank_n && split_transfer_flag)[*6] |-> shift_clk_out)
		else $error("flag not passed to shift clock");
endmodule : vcip_top_props

bind vcip_top vcip_top_props u_vcip_top_props (
	.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_clk_in(loop_clk_in), .legacy_dot_clk_in(legacy_dot_clk_in),
	.split_transfer_flag(split_transfer_flag), .shift_clk_out(shift_clk_out), .dac_blank_n(dac_blank_n),
	.dac_pixel(dac_pixel), .hsync_output(hsync_output), .vsync_output(vsync_output)
);

// ---- hdl/vcip_delay.sv ----
`timescale 1ns/1ps
module vcip_delay
	import vcip_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter int DEPTH = 3
) (
	// Clock and reset.
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	// Advance strobe and data.
	input  wire logic             shift_en,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] stage_r [DEPTH];

	// -------------------------------------------------------------
	// Delay line that advances once per latching edge of the link.
	// -------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage_r[i] <= '0;
			end
		end else if (shift_en) begin
			stage_r[0] <= d;
			for (int i = 1; i < DEPTH; i++) begin
				stage_r[i] <= stage_r[i-1];
			end
		end
	end

	assign q = stage_r[DEPTH-1];

endmodule : vcip_delay

// ---- hdl/vcip_pkg.sv ----
package vcip_pkg;

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 8;
	localparam logic [7:0]  REG_GEN_CTRL  = 8'h1D;
	localparam logic [7:0]  REG_MODE      = 8'h40;
	localparam logic [7:0]  REG_STATUS    = 8'h41;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int          GCR_HS_INV    = 0;
	localparam int          GCR_VS_INV    = 1;
	localparam logic [7:0]  GCR_RESET     = 8'h00;
	localparam int          MODE_LSB      = 0;
	localparam int          MODE_W        = 3;
	localparam int          MODE_PIX_LEG  = 3;
	localparam logic [7:0]  MODE_RESET    = 8'h02;

	// ----------------------------------------------------------------
	// Operating modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_SYSTEM  = 3'h0,
		MODE_LEGACY1 = 3'h1,
		MODE_LEGACY2 = 3'h2
	} vcip_mode_t;

	// ----------------------------------------------------------------
	// Pipeline and crossing
	// ----------------------------------------------------------------
	localparam int          PIX_W         = 8;
	localparam int          PIPE_DEPTH    = 3;
	localparam int          SYNC_STAGES   = 2;

	// True in the mode that latches on the legacy dot clock.
	function automatic logic vcip_is_legacy2(input logic [2:0] mode);
		return mode == MODE_LEGACY2;
	endfunction : vcip_is_legacy2

	// True in any mode that may take pixels from the legacy port.
	function automatic logic vcip_is_legacy(input logic [2:0] mode);
		return (mode == MODE_LEGACY1) || (mode == MODE_LEGACY2);
	endfunction : vcip_is_legacy

endpackage : vcip_pkg

// ---- hdl/vcip_sync.sv ----
`timescale 1ns/1ps
module vcip_sync
	import vcip_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	// Asynchronous inputs and their synchronised copies.
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// -------------------------------------------------------------
	// Two flip-flops; the first is read only by the second.
	// -------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : vcip_sync

// ---- hdl/vcip_top.sv ----
`timescale 1ns/1ps
module vcip_top
	import vcip_pkg::*;
#(
	parameter int PIPE_D = PIPE_DEPTH
) (
	// Clock and reset.
	input  wire logic              sys_clk,
	input  wire logic              rstn,

	// Register port.
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,

	// Link clocks from the pins.
	input  wire logic              loop_clk_in,
	input  wire logic              legacy_dot_clk_in,

	// System controller video controls and pixels.
	input  wire logic              sys_blank_n,
	input  wire logic              sys_hsync_in,
	input  wire logic              sys_vsync_in,
	input  wire logic [PIX_W-1:0]  sys_pixel_port,

	// Legacy controller video controls and pixels.
	input  wire logic              legacy_blank_n,
	input  wire logic              legacy_hsync_in,
	input  wire logic              legacy_vsync_in,
	input  wire logic [PIX_W-1:0]  legacy_pixel_port,

	// Memory shift clock control.
	input  wire logic              split_transfer_flag,
	output logic                   shift_clk_out,

	// Toward the converters and the sync pins.
	output logic                   dac_blank_n,
	output logic [PIX_W-1:0]       dac_pixel,
	output logic                   hsync_output,
	output logic                   vsync_output
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int PIN_W = 2 + 3 + PIX_W + 3 + PIX_W + 1;
	localparam int PIPE_W = 3 + PIX_W;

	logic [DATA_W-1:0] gen_ctrl_r;
	logic [DATA_W-1:0] mode_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic [PIN_W-1:0]  pins_async;
	logic [PIN_W-1:0]  pins_sync;

	logic              loop_clk_s;
	logic              dot_clk_s;
	logic              sys_blank_s;
	logic              sys_hs_s;
	logic              sys_vs_s;
	logic [PIX_W-1:0]  sys_pix_s;
	logic              leg_blank_s;
	logic              leg_hs_s;
	logic              leg_vs_s;
	logic [PIX_W-1:0]  leg_pix_s;
	logic              split_flag_s;

	logic              loop_clk_prev_r;
	logic              dot_clk_prev_r;
	logic              loop_rise;
	logic              dot_rise;
	logic              capture;

	logic [2:0]        cur_mode;
	logic              legacy2;
	logic              use_leg_pix;
	logic              sel_blank_n;
	logic              sel_hs;
	logic              sel_vs;
	logic [PIX_W-1:0]  sel_pix;
	logic [PIPE_W-1:0] pipe_in;
	logic [PIPE_W-1:0] pipe_out;
	logic              pipe_blank_n;
	logic              pipe_hs;
	logic              pipe_vs;
	logic [PIX_W-1:0]  pipe_pix;

	logic              dac_blank_n_r;
	logic [PIX_W-1:0]  dac_pixel_r;
	logic              hsync_r;
	logic              vsync_r;
	logic              shift_clk_r;
	logic              shift_clk_nxt;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------

	// Every link pin is brought onto sys_clk before any logic looks at it; the register port is used directly.
	// The link clocks pass the same two stages as the data, so a word
	// and the edge that latches it see equal latency.
	// Limitation: a pin that changes within about one sys_clk period of
	// its link edge may land on either side, so the controller must keep
	// its data steady around the latching edge.
	assign pins_async = {loop_clk_in, legacy_dot_clk_in,
		sys_blank_n, sys_hsync_in, sys_vsync_in, sys_pixel_port,
		legacy_blank_n, legacy_hsync_in, legacy_vsync_in, legacy_pixel_port,
		split_transfer_flag};

	vcip_sync #(
		.WIDTH    (PIN_W)
	) u_pin_sync (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.async_in (pins_async),
		.sync_out (pins_sync)
	);

	// Unpack the synchronised pins in the same order they were packed.
	assign {loop_clk_s, dot_clk_s,
		sys_blank_s, sys_hs_s, sys_vs_s, sys_pix_s,
		leg_blank_s, leg_hs_s, leg_vs_s, leg_pix_s,
		split_flag_s} = pins_sync;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------

	// Writes take effect on the strobe edge; unmapped writes are dropped.
	// Software never waits: the output stage sees a write on the very
	// next cycle.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			gen_ctrl_r <= GCR_RESET;
			mode_r     <= MODE_RESET;
		end else if (reg_wr) begin
			if (reg_addr == REG_GEN_CTRL) begin
				gen_ctrl_r <= reg_wdata;
			end else if (reg_addr == REG_MODE) begin
				mode_r     <= reg_wdata;
			end
		end
	end

	// Read decode; unmapped addresses and idle cycles read as zero.
	always_comb begin
		rdata_nxt = '0;
		if (reg_rd) begin
			if (reg_addr == REG_GEN_CTRL) begin
				rdata_nxt = gen_ctrl_r;
			end else if (reg_addr == REG_MODE) begin
				rdata_nxt = mode_r;
			end else if (reg_addr == REG_STATUS) begin
				rdata_nxt = {2'h0, shift_clk_r, legacy2, use_leg_pix,
					dac_blank_n_r, vsync_r, hsync_r};
			end
		end
	end

	// Read data stand for exactly the cycle after the strobe.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------

	// The source is recomputed every cycle, so a mode write switches it
	// at once; words already in the pipeline drain out unchanged.
	assign cur_mode    = mode_r[MODE_LSB +: MODE_W];
	assign legacy2     = vcip_is_legacy2(cur_mode);
	assign use_leg_pix = vcip_is_legacy(cur_mode) && mode_r[MODE_PIX_LEG];

	// ----------------------------------------------------------------
	// Latching edge of the active link clock
	// ----------------------------------------------------------------

	// Previous samples for rising edge detection.
	// They reset low, the idle level of a stopped link clock, so no false
	// capture follows reset.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			loop_clk_prev_r <= 1'b0;
			dot_clk_prev_r  <= 1'b0;
		end else begin
			loop_clk_prev_r <= loop_clk_s;
			dot_clk_prev_r  <= dot_clk_s;
		end
	end

	assign loop_rise = loop_clk_s && !loop_clk_prev_r;
	assign dot_rise  = dot_clk_s && !dot_clk_prev_r;

	// Legacy mode 2 latches on the dot clock, all others on the loop clock.
	assign capture = legacy2 ? dot_rise : loop_rise;

	// ----------------------------------------------------------------
	// Source selection
	// ----------------------------------------------------------------

	// Blank and sync come from one set or the other, never mixed.
	// Splitting the choice would let a mode write pair one controller's
	// blank with the other's sync.
	always_comb begin
		if (legacy2) begin
			sel_blank_n = leg_blank_s;
			sel_hs      = leg_hs_s;
			sel_vs      = leg_vs_s;
		end else begin
			sel_blank_n = sys_blank_s;
			sel_hs      = sys_hs_s;
			sel_vs      = sys_vs_s;
		end
	end

	// The legacy port feeds one pixel per latching edge with no multiplexing.
	assign sel_pix = use_leg_pix ? leg_pix_s : sys_pix_s;

	// ----------------------------------------------------------------
	// Pixel pipeline
	// ----------------------------------------------------------------

	// One delay line carries blank, sync and pixel together, so the
	// controls can never slip against the pixel of the same clock.
	// Latency: a word latched on edge k leaves the line after PIPE_D
	// latching edges and one more sys_clk through the output register.
	assign pipe_in = {sel_blank_n, sel_hs, sel_vs, sel_pix};

	vcip_delay #(
		.WIDTH    (PIPE_W),
		.DEPTH    (PIPE_D)
	) u_pipe (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.shift_en (capture),
		.d        (pipe_in),
		.q        (pipe_out)
	);

	assign {pipe_blank_n, pipe_hs, pipe_vs, pipe_pix} = pipe_out;

	// ----------------------------------------------------------------
	// Converter and sync outputs
	// ----------------------------------------------------------------

	// Registered outputs; polarity inversion is applied after the delay
	// so a control write flips the pin without waiting for the pipeline.
	// Reset leaves the converters blanked until real data fill the line.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dac_blank_n_r <= 1'b0;
			dac_pixel_r   <= '0;
			hsync_r       <= 1'b0;
			vsync_r       <= 1'b0;
		end else begin
			dac_blank_n_r <= pipe_blank_n;
			dac_pixel_r   <= pipe_pix;
			hsync_r       <= pipe_hs ^ gen_ctrl_r[GCR_HS_INV];
			vsync_r       <= pipe_vs ^ gen_ctrl_r[GCR_VS_INV];
		end
	end

	assign dac_blank_n  = dac_blank_n_r;
	assign dac_pixel    = dac_pixel_r;
	assign hsync_output = hsync_r;
	assign vsync_output = vsync_r;

	// ----------------------------------------------------------------
	// Memory shift clock
	// ----------------------------------------------------------------

	// Outside blank the shift clock follows the loop clock; during blank
	// it is held low except for split transfer pulses, which pass through.
	// The gate uses the delayed blank so it matches what the converters see.
	// Limitation: the copy is sampled on sys_clk, so its edges carry up to
	// one sys_clk period of jitter plus the synchroniser latency.
	// The pin is registered so it never glitches when blank and the loop
	// clock change in the same cycle.
	always_comb begin
		if (pipe_blank_n) begin
			shift_clk_nxt = loop_clk_s;
		end else begin
			shift_clk_nxt = split_flag_s;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			shift_clk_r <= 1'b0;
		end else begin
			shift_clk_r <= shift_clk_nxt;
		end
	end

	assign shift_clk_out = shift_clk_r;

endmodule : vcip_top
